// ==== inc/tie_regs.vh ====
// register offsets, field positions and reset values for the timer irq block
`ifndef TIE_REGS_VH
`define TIE_REGS_VH
`define TIE_ADDR_W        4
`define TIE_OFF_EN0       4'h0
`define TIE_OFF_EN1       4'h1
`define TIE_OFF_EN2       4'h2
`define TIE_OFF_ST0       4'h4
`define TIE_OFF_ST1       4'h5
`define TIE_OFF_ST2       4'h6
`define TIE_OFF_DIR       4'h8
`define TIE_EN_RESET      8'h40
`define TIE_ST_RESET      8'hC0
`define TIE_EN_MASK_CH0   8'h9F
`define TIE_EN_MASK_CH12  8'hB3
`define TIE_ST_MASK_CH0   8'h1F
`define TIE_ST_MASK_CH12  8'h33
`define TIE_ST_ONES_CH0   8'hC0
`define TIE_ST_ONES_CH12  8'h40
`define TIE_BIT_ADC       7
`define TIE_BIT_DIR       7
`define TIE_BIT_FIXED     6
`define TIE_BIT_UDF       5
`define TIE_BIT_OVF       4
`define TIE_BIT_D         3
`define TIE_BIT_C         2
`define TIE_BIT_B         1
`define TIE_BIT_A         0
`define TIE_CNT_MAX       16'hFFFF
`define TIE_CNT_MIN       16'h0000
`endif

// ==== verilog/tie_event_detect.v ====
// counter wrap and general register match/capture event detector
`timescale 1ns/1ps
`default_nettype none
`include "tie_regs.vh"
module tie_event_detect #(
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          sys_rst,
  input  wire [CW-1:0] channel_counter,
  input  wire          cnt_step,
  input  wire          count_up,
  input  wire [3:0]    is_capture,
  input  wire [3:0]    capture_in,
  input  wire [CW-1:0] general_reg_a,
  input  wire [CW-1:0] general_reg_b,
  input  wire [CW-1:0] general_reg_c,
  input  wire [CW-1:0] general_reg_d,
  output wire          ovf_evt,
  output wire          udf_evt,
  output wire [3:0]    match_evt
);
  reg  [CW-1:0] prev_r;
  reg           step_d_r;
  reg           up_d_r;
  wire [CW-1:0] grs [0:3];
  assign grs[0] = general_reg_a;
  assign grs[1] = general_reg_b;
  assign grs[2] = general_reg_c;
  assign grs[3] = general_reg_d;
  // remember the previous count so a wrap is seen as a transition
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      prev_r   <= {CW{1'b0}};
      step_d_r <= 1'b0;
      up_d_r   <= 1'b1;
    end
    else
    begin
      prev_r   <= channel_counter;
      step_d_r <= cnt_step;
      up_d_r   <= count_up;
    end
  end
  // wrap up ffff->0000 and down 0000->ffff
  assign ovf_evt = step_d_r & up_d_r & (prev_r == {CW{1'b1}})
                   & (channel_counter == {CW{1'b0}});
  assign udf_evt = step_d_r & ~up_d_r & (prev_r == {CW{1'b0}})
                   & (channel_counter == {CW{1'b1}});
  // compare equality only on a counting step, so a held count flags once
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_match
      assign match_evt[g] = is_capture[g] ? capture_in[g]
                          : (step_d_r & (channel_counter == grs[g]));
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verilog/tie_flag_bit.v ====
// one status flag: hardware set, read-then-write-zero clear
`timescale 1ns/1ps
`default_nettype none
module tie_flag_bit (
  input  wire clk,
  input  wire sys_rst,
  input  wire standby,
  input  wire set_evt,
  input  wire rd_seen,
  input  wire wr_zero,
  input  wire hw_clr,
  output wire flag
);
  reg flag_r;
  reg armed_r;
  // armed after software has read the flag as 1
  always @(posedge clk)
  begin
    if (sys_rst | standby)
    begin
      flag_r  <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      if (set_evt)
        flag_r <= 1'b1;
      else if ((wr_zero & armed_r) | hw_clr)
        flag_r <= 1'b0;
      if (set_evt | wr_zero | hw_clr)
        armed_r <= 1'b0;
      else if (rd_seen & flag_r)
        armed_r <= 1'b1;
    end
  end
  assign flag = flag_r;
endmodule
`default_nettype wire

// ==== verilog/tie_timer_irq.v ====
// interrupt enable and status flags for a three-channel 16-bit timer
// What this block does
// - enable registers load 40 hex on reset or standby entry
// - status registers load C0 hex on reset or standby entry
// - three 8-bit enable registers; ch0 bits 7,4..0, ch1/2 bits 7,5,4,1,0
// - enable bit 7 passes match-A events as converter start requests
// - enable bit 6 is read-only one; software writes one
// - ch1/2 bit 5 enables underflow request; reads zero in ch0
// - bit 4 enables overflow request in every channel
// - ch0 bit 3 enables match-D request; ch1/2 reserved zero
// - ch0 bit 2 enables match-C request; ch1/2 reserved zero
// - bit 1 enables match-B request in every channel
// - bit 0 enables match-A request in every channel
// - status flags clear by writing zero; writing one does nothing
// - zero write clears only after the flag was read as one
// - ch1/2 status bit 7 shows count direction; ch0 reads one
// - status bit 6 is read-only one; software writes one
// - ch1/2 bit 5 sets on wrap 0000 to FFFF; ch0 zero
// - bit 4 sets on upward wrap FFFF to 0000
// - ch0 bit 3 sets on compare equality with register D
// - ch0 bit 3 also sets on capture into register D
// - flags A, B, C set on compare or capture; C in ch0 only
// - match-A flag also clears on its triggered dma transfer
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tie_regs.vh"
module tie_timer_irq #(
  parameter CW = 16
) (
  input  wire                   clk,
  input  wire                   sys_rst,
  input  wire                   standby,
  input  wire [`TIE_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr,
  input  wire                   rd,
  output reg  [7:0]             rdata,
  input  wire [3*CW-1:0]        channel_counter,
  input  wire [2:0]             cnt_step,
  input  wire [2:0]             count_up,
  input  wire [11:0]            is_capture,
  input  wire [11:0]            capture_in,
  input  wire [3*CW-1:0]        general_reg_a,
  input  wire [3*CW-1:0]        general_reg_b,
  input  wire [CW-1:0]          general_reg_c,
  input  wire [CW-1:0]          general_reg_d,
  input  wire [2:0]             dma_done_a,
  output wire [2:0]             adc_start_req,
  output wire [2:0]             overflow_irq,
  output wire [2:0]             underflow_irq,
  output wire [2:0]             match_a_irq,
  output wire [2:0]             match_b_irq,
  output wire                   match_c_irq,
  output wire                   match_d_irq
);
  // per-channel enable storage, status flags and events
  reg  [7:0]  en_r [0:2];
  wire [7:0]  en_mask [0:2];
  wire [7:0]  st_val [0:2];
  wire [7:0]  st_mask [0:2];
  wire [2:0]  ovf_evt;
  wire [2:0]  udf_evt;
  wire [11:0] match_evt;
  wire [4:0]  flg [0:2];
  wire        rst_any = sys_rst | standby;
  assign en_mask[0] = `TIE_EN_MASK_CH0;
  assign en_mask[1] = `TIE_EN_MASK_CH12;
  assign en_mask[2] = `TIE_EN_MASK_CH12;
  assign st_mask[0] = `TIE_ST_MASK_CH0;
  assign st_mask[1] = `TIE_ST_MASK_CH12;
  assign st_mask[2] = `TIE_ST_MASK_CH12;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1)
    begin : g_ch
      wire [3:0]    evt4;
      wire          is_st;
      wire          is_en;
      wire [CW-1:0] grc;
      wire [CW-1:0] grd;
      wire [3:0]    cap_sel;
      // channels 1/2 have no C/D registers, so their events stay low
      if (ch == 0)
      begin : g_cd
        assign grc     = general_reg_c;
        assign grd     = general_reg_d;
        assign cap_sel = is_capture[3:0];
      end
      else
      begin : g_nocd
        assign grc     = {CW{1'b0}};
        assign grd     = {CW{1'b0}};
        assign cap_sel = {2'b11, is_capture[4*ch+1 -: 2]};
      end
      tie_event_detect #(
        .CW (CW)
      ) u_det (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .channel_counter (channel_counter[CW*ch +: CW]),
        .cnt_step        (cnt_step[ch]),
        .count_up        (count_up[ch]),
        .is_capture      (cap_sel),
        .capture_in      (ch == 0 ? capture_in[3:0]
                                  : {2'b00, capture_in[4*ch+1 -: 2]}),
        .general_reg_a   (general_reg_a[CW*ch +: CW]),
        .general_reg_b   (general_reg_b[CW*ch +: CW]),
        .general_reg_c   (grc),
        .general_reg_d   (grd),
        .ovf_evt         (ovf_evt[ch]),
        .udf_evt         (udf_evt[ch]),
        .match_evt       (evt4)
      );
      assign match_evt[4*ch +: 4] = evt4;
      assign is_st = (addr == (`TIE_OFF_ST0 + ch));
      assign is_en = (addr == (`TIE_OFF_EN0 + ch));

      // enable register: only implemented bits store, bit 6 fixed at one
      always @(posedge clk)
      begin
        if (rst_any)
          en_r[ch] <= `TIE_EN_RESET;
        else if (wr & is_en)
          en_r[ch] <= (wdata & en_mask[ch]) | `TIE_EN_RESET;
      end

      // flags: 0 = A, 1 = B, 2 = C, 3 = D, 4 = overflow; udf flags are built separately below
      genvar b;
      for (b = 0; b < 5; b = b + 1)
      begin : g_flag
        wire set_b;
        if (b == 4)
        begin : g_ovf
          assign set_b = ovf_evt[ch];
        end
        else
        begin : g_m
          assign set_b = evt4[b] & st_mask[ch][b];
        end
        tie_flag_bit u_flag (
          .clk     (clk),
          .sys_rst (sys_rst),
          .standby (standby),
          .set_evt (set_b),
          .rd_seen (rd & is_st),
          .wr_zero (wr & is_st & ~wdata[b]),
          .hw_clr  (b == 0 ? dma_done_a[ch] : 1'b0),
          .flag    (flg[ch][b])
        );
      end
    end
  endgenerate

  // underflow flags exist only in channels 1 and 2
  wire [2:1] udf_flag;
  genvar u;
  generate
    for (u = 1; u < 3; u = u + 1)
    begin : g_udf
      tie_flag_bit u_uflag (
        .clk     (clk),
        .sys_rst (sys_rst),
        .standby (standby),
        .set_evt (udf_evt[u]),
        .rd_seen (rd & (addr == (`TIE_OFF_ST0 + u))),
        .wr_zero (wr & (addr == (`TIE_OFF_ST0 + u))
                  & ~wdata[`TIE_BIT_UDF]),
        .hw_clr  (1'b0),
        .flag    (udf_flag[u])
      );
    end
  endgenerate

  // status read images; fixed ones fill bit 6 and ch0 bit 7
  assign st_val[0] = `TIE_ST_ONES_CH0 | {3'b000, flg[0]};
  assign st_val[1] = `TIE_ST_ONES_CH12
                   | {count_up[1], 1'b0, udf_flag[1], flg[1][4], 2'b00,
                      flg[1][1:0]};
  assign st_val[2] = `TIE_ST_ONES_CH12
                   | {count_up[2], 1'b0, udf_flag[2], flg[2][4], 2'b00,
                      flg[2][1:0]};

  // irq requests are plain AND of flag and enable, no extra latching
  genvar q;
  generate
    for (q = 0; q < 3; q = q + 1)
    begin : g_req
      assign overflow_irq[q] = flg[q][4]
                             & en_r[q][`TIE_BIT_OVF];
      assign match_a_irq[q]  = flg[q][0]
                             & en_r[q][`TIE_BIT_A];
      assign match_b_irq[q]  = flg[q][1]
                             & en_r[q][`TIE_BIT_B];
      // converter trigger follows each match-A event, not the sticky flag
      assign adc_start_req[q] = match_evt[4*q]
                              & en_r[q][`TIE_BIT_ADC];
    end
  endgenerate
  assign underflow_irq[0] = 1'b0;
  assign underflow_irq[1] = udf_flag[1] & en_r[1][`TIE_BIT_UDF];
  assign underflow_irq[2] = udf_flag[2] & en_r[2][`TIE_BIT_UDF];
  assign match_c_irq = flg[0][2] & en_r[0][`TIE_BIT_C];
  assign match_d_irq = flg[0][3] & en_r[0][`TIE_BIT_D];

  // read data appear one cycle after the strobe; unmapped reads zero
  always @(posedge clk)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `TIE_OFF_EN0: rdata <= en_r[0];
        `TIE_OFF_EN1: rdata <= en_r[1];
        `TIE_OFF_EN2: rdata <= en_r[2];
        `TIE_OFF_ST0: rdata <= st_val[0];
        `TIE_OFF_ST1: rdata <= st_val[1];
        `TIE_OFF_ST2: rdata <= st_val[2];
        default:      rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// ==== verification/tie_adc_model.sv ====
// converter-side partner that counts conversion start requests
`timescale 1ns/1ps
`default_nettype none
module tie_adc_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] adc_start_req,
  output var  int         starts
);
  // one start per request bit each cycle; a busy converter is not modelled
  always @(posedge clk)
    if (sys_rst)
      starts <= 0;
    else
      starts <= starts + $countones(adc_start_req);
endmodule
`default_nettype wire

// ==== verification/tie_timer_irq_assertions.sv ====
// port-level assertions for the timer interrupt enable and status block
`timescale 1ns/1ps
`default_nettype none
module tie_irq_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        standby,
  input wire logic [3:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic [2:0]  cnt_step,
  input wire logic [2:0]  count_up,
  input wire logic [11:0] capture_in,
  input wire logic [2:0]  dma_done_a,
  input wire logic [2:0]  adc_start_req,
  input wire logic [2:0]  overflow_irq,
  input wire logic [2:0]  underflow_irq,
  input wire logic [2:0]  match_a_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // no event may land near a clear, since a set would win over it
  sequence s_arm;
    !cnt_step[0] ##1 (!cnt_step[0] && capture_in[3:0] == 4'h0
      && rd && addr == 4'h4);
  endsequence
  sequence s_clr;
    !cnt_step[0] && capture_in[3:0] == 4'h0 && wr && addr == 4'h4
      && wdata == 8'hC0;
  endsequence
  property p_en0_fix;
    rd && addr == 4'h0 |=> rdata[6:5] == 2'b10;
  endproperty
  a_en0_fix: assert property (p_en0_fix)
    else $error("enable ch0 fixed bits wrong");
  property p_en12_fix;
    rd && (addr == 4'h1 || addr == 4'h2) |=> rdata[6] && rdata[3:2] == 2'h0;
  endproperty
  a_en12_fix: assert property (p_en12_fix)
    else $error("enable ch1/2 fixed bits wrong");
  property p_st0_fix;
    rd && addr == 4'h4 |=> rdata[7:5] == 3'h6;
  endproperty
  a_st0_fix: assert property (p_st0_fix)
    else $error("status ch0 fixed bits wrong");
  property p_st1_dir;
    rd && addr == 4'h5 |=> rdata[7] == $past(count_up[1]) && rdata[6];
  endproperty
  a_st1_dir: assert property (p_st1_dir)
    else $error("status ch1 direction bit wrong");
  property p_udf0;
    underflow_irq[0] == 1'b0;
  endproperty
  a_udf0: assert property (p_udf0)
    else $error("ch0 underflow request raised");
  property p_stby;
    standby |=> overflow_irq == 3'h0 && underflow_irq == 3'h0
      && match_a_irq == 3'h0 && adc_start_req == 3'h0;
  endproperty
  a_stby: assert property (p_stby)
    else $error("requests survive standby");
  property p_keep;
    match_a_irq[0] && wr && addr == 4'h4 && wdata == 8'hFF
      && !dma_done_a[0] && !standby |=> match_a_irq[0];
  endproperty
  a_keep: assert property (p_keep)
    else $error("writing one cleared a flag");
  property p_clr;
    s_arm ##1 s_clr |=> match_a_irq[0] == 1'b0 && overflow_irq[0] == 1'b0;
  endproperty
  a_clr: assert property (p_clr)
    else $error("read then zero write did not clear");
endmodule
bind tie_timer_irq tie_irq_chk u_tie_irq_chk (.clk, .sys_rst, .standby,
  .addr, .wdata, .wr, .rd, .rdata, .cnt_step, .count_up, .capture_in,
  .dma_done_a, .adc_start_req, .overflow_irq, .underflow_irq, .match_a_irq);
`default_nettype wire

// ==== verification/tb_tie_timer_irq.sv ====
// self-checking bench for the timer interrupt enable and status block
`timescale 1ns/1ps
`default_nettype none
module tb_tie_timer_irq;
  logic        clk, sys_rst, standby, wr, rd, match_c_irq, match_d_irq;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, d;
  logic [47:0] channel_counter, general_reg_a, general_reg_b;
  logic [15:0] general_reg_c, general_reg_d;
  logic [2:0]  cnt_step, count_up, dma_done_a, adc_start_req;
  logic [2:0]  overflow_irq, underflow_irq, match_a_irq, match_b_irq;
  logic [11:0] is_capture, capture_in;
  int          fail_count, samples_checked, starts;
  tie_timer_irq #(.CW(16)) u_tie_timer_irq (.clk, .sys_rst, .standby,
    .addr, .wdata, .wr, .rd, .rdata, .channel_counter, .cnt_step,
    .count_up, .is_capture, .capture_in, .general_reg_a, .general_reg_b,
    .general_reg_c, .general_reg_d, .dma_done_a, .adc_start_req,
    .overflow_irq, .underflow_irq, .match_a_irq, .match_b_irq,
    .match_c_irq, .match_d_irq);
  tie_adc_model u_tie_adc_model (.clk, .sys_rst, .adc_start_req, .starts);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(string nm, logic [7:0] s, logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // bus cycles: strobes one cycle long, data one cycle after a read
  task wr_reg(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rd_reg(logic [3:0] a);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // read then zero write back to back; bit 6 is written as one
  task clr(logic [3:0] a);
    rd_reg(a);
    {wdata, wr} <= {8'hC0, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // the step pulse leads the new count by one cycle, as the counter does;
  // the flag lands one edge after the count changes, so wait past that
  task step(int ch, logic [15:0] v);
    @(posedge clk);
    cnt_step[ch] <= 1'b1;
    @(posedge clk);
    cnt_step[ch] <= 1'b0;
    channel_counter[16*ch+:16] <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task t_reset;
    logic [3:0] al[7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8};
    logic [7:0] ev[7] = '{8'h40, 8'h40, 8'h40, 8'hC0, 8'hC0, 8'hC0, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      rd_reg(al[i]);
      chk("reset value", d, ev[i]);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(i[3:0], 8'hFF);
      rd_reg(i[3:0]);
      chk("enable mask", d, i == 0 ? 8'hDF : 8'hF3);
    end
    $display("test reset and enables done");
  endtask
  task t_match;
    step(0, 16'h0010);
    chk("match a irq", match_a_irq, 3'h1);
    chk("adc starts", starts[7:0], 8'h01);
    step(0, 16'h0030);
    @(posedge clk);
    capture_in[3] <= 1'b1;
    @(posedge clk);
    capture_in[3] <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("c d irq", {match_c_irq, match_d_irq}, 2'h3);
    // a zero write with no read of the flag before it must not clear
    wr_reg(4'h4, 8'hFF);
    wr_reg(4'h4, 8'hC0);
    chk("kept", {match_a_irq[0], match_d_irq}, 2'h3);
    rd_reg(4'h4);
    chk("status 0", d, 8'hCD);
    clr(4'h4);
    chk("clr", {match_a_irq[0], match_c_irq, match_d_irq}, 3'h0);
    step(0, 16'h0020);
    chk("match b irq", match_b_irq, 3'h1);
    // register D switched to compare so equality sets its flag
    is_capture[3] <= 1'b0;
    step(0, 16'h0040);
    chk("match d cmp", match_d_irq, 1'b1);
    $display("test match done");
  endtask
  task t_wrap;
    step(1, 16'hFFFE);
    step(1, 16'hFFFF);
    step(1, 16'h0000);
    chk("ovf irq", overflow_irq, 3'h2);
    count_up[1] <= 1'b0;
    step(1, 16'hFFFF);
    chk("udf irq", underflow_irq, 3'h2);
    rd_reg(4'h5);
    chk("status 1", d, 8'h70);
    wr_reg(4'h1, 8'hE3);
    chk("ovf masked", {overflow_irq[1], underflow_irq[1]}, 2'h1);
    wr_reg(4'h1, 8'hC3);
    chk("udf masked", underflow_irq, 3'h0);
    count_up[1] <= 1'b1;
    wr_reg(4'h1, 8'h41);
    step(1, 16'h0100);
    chk("no adc", {match_a_irq[1], starts[6:0]}, 8'h81);
    @(posedge clk);
    dma_done_a[1] <= 1'b1;
    @(posedge clk);
    dma_done_a[1] <= 1'b0;
    #1 chk("dma clear", match_a_irq, 3'h0);
    $display("test wrap and dma done");
  endtask
  task t_standby;
    step(0, 16'h0010);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    #1 chk("stby irq", {match_a_irq, match_b_irq}, 6'h00);
    rd_reg(4'h4);
    chk("stby status", d, 8'hC0);
    rd_reg(4'h0);
    chk("stby enable", d, 8'h40);
    $display("test standby done");
  endtask
  initial
  begin
    {sys_rst, standby, wr, rd, addr, wdata} = {4'h8, 4'h0, 8'h00};
    {cnt_step, dma_done_a, capture_in, channel_counter} = '0;
    {count_up, is_capture} = {3'h7, 12'h008};
    general_reg_a = {16'h0500, 16'h0100, 16'h0010};
    general_reg_b = {16'h0600, 16'h0200, 16'h0020};
    {general_reg_c, general_reg_d} = {16'h0030, 16'h0040};
    {fail_count, samples_checked} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_match;
    t_wrap;
    t_standby;
    report_and_stop;
  end
  // watchdog far beyond the 125 or so cycles the tests need
  initial
  begin
    #100000;
    fail_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
